// >>> verilog/peak_det_pkg.sv
// Constants shared by the block peak power detector
package peak_det_pkg;
    // ************************************************
    // Register indices, byte address is index times 4
    // ************************************************
    localparam logic [7:0] IDX_ENABLE = 8'h00;
    localparam logic [7:0] IDX_LEN_LOW = 8'h01;
    localparam logic [7:0] IDX_LEN_MID = 8'h02;
    localparam logic [7:0] IDX_LEN_TOP = 8'h03;
    localparam logic [7:0] IDX_UPPER_A = 8'h07;
    localparam logic [7:0] IDX_LOWER_A = 8'h08;
    localparam logic [7:0] IDX_UPPER_B = 8'h09;
    localparam logic [7:0] IDX_LOWER_B = 8'h0A;
    localparam logic [7:0] IDX_HOLD_LOW = 8'h0B;
    localparam logic [7:0] IDX_HOLD_HIGH = 8'h0C;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    localparam logic [7:0] IDX_MASK = 8'h11;
    localparam logic [7:0] IDX_LIVE = 8'h12;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [REG_W-1:0] REG_RST = 8'h00;
    // ************************************************
    // Datapath widths
    // ************************************************
    localparam int LANES = 8;
    localparam int SAMP_W = 14;
    localparam int MAG_W = 14;
    localparam int LVL_SHIFT = 5;
    localparam int LVL_W = 9;
    localparam int LEN_W = 17;
    localparam int HOLD_W = 16;
    // ************************************************
    // Status bits
    // ************************************************
    localparam int ST_W = 3;
    localparam int ST_SET_A = 0;
    localparam int ST_SET_B = 1;
    localparam int ST_BLOCK = 2;
endpackage : peak_det_pkg

// >>> verilog/peak_flag_channel.sv
// Hysteresis alarm flag with hold-off before release
`timescale 1ns/100ps
module peak_flag_channel
    import peak_det_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Block peak
    input wire logic enable,
    input wire logic blk_valid,
    input wire logic [LVL_W-1:0] level,
    // Settings
    input wire logic [REG_W-1:0] upper,
    input wire logic [REG_W-1:0] lower,
    input wire logic [HOLD_W-1:0] hold_off_period,
    // Result
    output logic flag_r
);
    logic below_r;
    logic [HOLD_W-1:0] cnt_r;
    logic over;
    logic under;

    // Threshold 256 means full peak, so compare at 9 bits
    assign over = level > {1'b0, upper}; // [R7]
    assign under = level < {1'b0, lower}; // [R7]

    // ************************************************
    // Flag, set on crossing, released after hold-off
    // ************************************************
    // A new block always wins over a pending release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
            below_r <= 1'b0;
            cnt_r <= '0;
        end else if (!enable) begin
            flag_r <= 1'b0;
            below_r <= 1'b0;
            cnt_r <= '0;
        end else if (blk_valid) begin
            if (over) begin
                flag_r <= 1'b1; // [R8]
            end
            below_r <= under;
            cnt_r <= '0; // [R9]
        end else if (flag_r && below_r) begin
            if (cnt_r >= hold_off_period) begin
                flag_r <= 1'b0; // [R9]
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    flag_set_a: assert property ( // [R8]
        @(posedge clk) disable iff (rst)
        enable && blk_valid && over |=> flag_r)
        else $error("flag not set on upper crossing");
    flag_release_a: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        $fell(flag_r) && $past(enable) |->
        $past(below_r) && $past(cnt_r) >= $past(hold_off_period))
        else $error("flag released before hold-off");
    hold_restart_a: assert property ( // [R9]
        @(posedge clk) disable iff (rst)
        enable && blk_valid |=> cnt_r == '0)
        else $error("hold-off count not restarted");
endmodule : peak_flag_channel

// >>> verilog/peak_detector.sv
// Block peak power detector with APB registers
`timescale 1ns/100ps
// Functional notes
// R1 - Detection runs only while enable bit is one; it resets to zero.
// R2 - Each block peak spans the programmed count of reduced samples.
// R3 - A reduced sample is the largest magnitude of eight samples.
// R4 - Block length is 17 bits over low, mid and single top-bit registers.
// R5 - Software: decimation by 4 or 6 needs length multiple of 5 x factor.
// R6 - Software: decimation 8 to 32 needs length multiple of 10 x factor.
// R7 - Four 8-bit thresholds, 256 meaning full peak, compared to block peak.
// R8 - A block peak above an upper threshold sets its alarm flag.
// R9 - Flag clears after peak stays below lower threshold for hold-off; code restarts the hold-off count at every block, below or not.
// R10 - Accumulation restarts after each block; blocks never overlap.
module peak_detector
    import peak_det_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter samples, eight per clock
    input wire logic SAMPLE_VALID,
    input wire logic [LANES*SAMP_W-1:0] SAMPLE_DATA,
    // Results
    output logic BLOCK_STROBE,
    output logic [MAG_W-1:0] BLOCK_PEAK,
    output logic FLAG_A,
    output logic FLAG_B,
    output logic IRQ
);
    // ************************************************
    // Declarations
    // ************************************************
    logic det_en_r;
    logic [REG_W-1:0] len_low_r;
    logic [REG_W-1:0] len_mid_r;
    logic len_top_r;
    logic [REG_W-1:0] upper_a_r;
    logic [REG_W-1:0] lower_a_r;
    logic [REG_W-1:0] upper_b_r;
    logic [REG_W-1:0] lower_b_r;
    logic [HOLD_W-1:0] hold_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [ST_W-1:0] events;
    logic [LEN_W-1:0] block_length;
    logic [MAG_W-1:0] red_nxt;
    logic [MAG_W-1:0] red_r;
    logic red_vld_r;
    logic [MAG_W-1:0] acc_r;
    logic [MAG_W-1:0] acc_nxt;
    logic [LEN_W-1:0] cnt_r;
    logic blk_last;
    logic blk_vld_r;
    logic [MAG_W-1:0] peak_r;
    logic [LVL_W-1:0] level;
    logic flag_a;
    logic flag_b;
    logic flag_a_d_r;
    logic flag_b_d_r;
    logic access;
    logic wr_take;
    logic [7:0] idx;
    logic idx_ok;
    logic mapped;
    logic [REG_W-1:0] rd_val;

    // ************************************************
    // APB decode
    // ************************************************
    // One wait state: data is registered, never combinational
    assign access = PSEL && PENABLE && !PREADY;
    assign wr_take = PSEL && PENABLE && PREADY && PWRITE;
    assign idx = PADDR[IDX_LSB+7:IDX_LSB];
    assign idx_ok = (PADDR[IDX_LSB-1:0] == '0)
        && (PADDR[ADDR_W-1:IDX_LSB+8] == '0);

    always_comb begin
        mapped = idx_ok;
        rd_val = REG_RST;
        case (idx)
            IDX_ENABLE: rd_val = {7'h00, det_en_r};
            IDX_LEN_LOW: rd_val = len_low_r;
            IDX_LEN_MID: rd_val = len_mid_r;
            IDX_LEN_TOP: rd_val = {7'h00, len_top_r};
            IDX_UPPER_A: rd_val = upper_a_r;
            IDX_LOWER_A: rd_val = lower_a_r;
            IDX_UPPER_B: rd_val = upper_b_r;
            IDX_LOWER_B: rd_val = lower_b_r;
            IDX_HOLD_LOW: rd_val = hold_r[7:0];
            IDX_HOLD_HIGH: rd_val = hold_r[15:8];
            IDX_STATUS: rd_val = {5'h00, status_r};
            IDX_MASK: rd_val = {5'h00, mask_r};
            IDX_LIVE: rd_val = {6'h00, flag_b, flag_a};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access;
            PSLVERR <= access && !mapped;
            if (access && !PWRITE) begin
                PRDATA <= {24'h000000, rd_val};
            end
        end
    end

    // ************************************************
    // Configuration registers
    // ************************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            det_en_r <= 1'b0; // [R1]
            len_low_r <= REG_RST;
            len_mid_r <= REG_RST;
            len_top_r <= 1'b0;
            upper_a_r <= REG_RST;
            lower_a_r <= REG_RST;
            upper_b_r <= REG_RST;
            lower_b_r <= REG_RST;
            hold_r <= '0;
            mask_r <= '0;
        end else if (wr_take && idx_ok) begin
            case (idx)
                IDX_ENABLE: det_en_r <= PWDATA[0]; // [R1]
                IDX_LEN_LOW: len_low_r <= PWDATA[7:0]; // [R4]
                IDX_LEN_MID: len_mid_r <= PWDATA[7:0]; // [R4]
                IDX_LEN_TOP: len_top_r <= PWDATA[0]; // [R4]
                IDX_UPPER_A: upper_a_r <= PWDATA[7:0]; // [R7]
                IDX_LOWER_A: lower_a_r <= PWDATA[7:0]; // [R7]
                IDX_UPPER_B: upper_b_r <= PWDATA[7:0]; // [R7]
                IDX_LOWER_B: lower_b_r <= PWDATA[7:0]; // [R7]
                IDX_HOLD_LOW: hold_r[7:0] <= PWDATA[7:0];
                IDX_HOLD_HIGH: hold_r[15:8] <= PWDATA[7:0];
                IDX_MASK: mask_r <= PWDATA[ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Software must keep length a multiple of the decimation rule
    assign block_length = {len_top_r, len_mid_r, len_low_r}; // [R4]

    // ************************************************
    // Reduced sample: peak of eight magnitudes
    // ************************************************
    always_comb begin
        logic signed [SAMP_W-1:0] s;
        logic [MAG_W-1:0] m;
        s = '0;
        m = '0;
        red_nxt = '0;
        for (int i = 0; i < LANES; i++) begin
            s = SAMPLE_DATA[i*SAMP_W +: SAMP_W];
            m = s[SAMP_W-1] ? MAG_W'(-s) : MAG_W'(s);
            if (m > red_nxt) begin
                red_nxt = m; // [R3]
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            red_r <= '0;
            red_vld_r <= 1'b0;
        end else begin
            red_vld_r <= det_en_r && SAMPLE_VALID; // [R1]
            if (SAMPLE_VALID) begin
                red_r <= red_nxt; // [R3]
            end
        end
    end

    // ************************************************
    // Block peak over the programmed length
    // ************************************************
    // A length of zero behaves as one to avoid a stuck block
    assign blk_last = ({1'b0, cnt_r} + 1'b1) >= {1'b0, block_length};
    assign acc_nxt = (red_r > acc_r) ? red_r : acc_r;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            acc_r <= '0;
            cnt_r <= '0;
            blk_vld_r <= 1'b0;
            peak_r <= '0;
        end else if (!det_en_r) begin
            acc_r <= '0; // [R1]
            cnt_r <= '0;
            blk_vld_r <= 1'b0;
        end else begin
            blk_vld_r <= red_vld_r && blk_last;
            if (red_vld_r) begin
                if (blk_last) begin
                    peak_r <= acc_nxt; // [R2]
                    acc_r <= '0; // [R10]
                    cnt_r <= '0; // [R10]
                end else begin
                    acc_r <= acc_nxt;
                    cnt_r <= cnt_r + 1'b1; // [R2]
                end
            end
        end
    end

    // Full scale magnitude 8192 maps to threshold 256
    assign level = LVL_W'(peak_r >> LVL_SHIFT); // [R7]

    // ************************************************
    // Alarm flags, pair A and pair B
    // ************************************************
    peak_flag_channel u_flag_a (
        .clk(REF_CLK),
        .rst(RST),
        .enable(det_en_r),
        .blk_valid(blk_vld_r),
        .level(level),
        .upper(upper_a_r),
        .lower(lower_a_r),
        .hold_off_period(hold_r),
        .flag_r(flag_a)
    );

    peak_flag_channel u_flag_b (
        .clk(REF_CLK),
        .rst(RST),
        .enable(det_en_r),
        .blk_valid(blk_vld_r),
        .level(level),
        .upper(upper_b_r),
        .lower(lower_b_r),
        .hold_off_period(hold_r),
        .flag_r(flag_b)
    );

    // ************************************************
    // Outputs, status and interrupt
    // ************************************************
    assign events = {blk_vld_r, flag_b && !flag_b_d_r,
        flag_a && !flag_a_d_r};

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            status_r <= '0;
        end else if (wr_take && idx_ok && idx == IDX_STATUS) begin
            status_r <= (status_r & ~PWDATA[ST_W-1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            flag_a_d_r <= 1'b0;
            flag_b_d_r <= 1'b0;
            FLAG_A <= 1'b0;
            FLAG_B <= 1'b0;
            BLOCK_STROBE <= 1'b0;
            BLOCK_PEAK <= '0;
            IRQ <= 1'b0;
        end else begin
            flag_a_d_r <= flag_a;
            flag_b_d_r <= flag_b;
            FLAG_A <= flag_a; // [R8] [R9]
            FLAG_B <= flag_b; // [R8] [R9]
            BLOCK_STROBE <= blk_vld_r;
            BLOCK_PEAK <= peak_r;
            IRQ <= |(status_r & mask_r);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    sequence apb_wait_s;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence apb_done_s;
        PREADY ##1 !PREADY;
    endsequence

    sequence last_sample_s;
        det_en_r && red_vld_r && blk_last;
    endsequence

    sequence strobe_out_s;
        blk_vld_r ##1 BLOCK_STROBE;
    endsequence

    apb_answer_a: assert property (@(posedge REF_CLK) disable iff (RST)
        apb_wait_s |=> apb_done_s)
        else $error("APB answer not one wait state");
    slave_error_a: assert property (@(posedge REF_CLK) disable iff (RST)
        PSLVERR |-> PREADY)
        else $error("slave error outside the access answer");
    detector_off_a: assert property ( // [R1]
        @(posedge REF_CLK) disable iff (RST)
        !det_en_r |=> !blk_vld_r && !red_vld_r && acc_r == '0)
        else $error("detector active while disabled");
    reduce_peak_a: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RST)
        SAMPLE_VALID |=> red_r >= $past(red_nxt)
        && red_r == $past(red_nxt))
        else $error("reduced sample is not the lane maximum");
    block_count_a: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST)
        det_en_r && red_vld_r && !blk_last |=> !blk_vld_r
        && cnt_r == $past(cnt_r) + 1'b1)
        else $error("block ended early");
    block_strobe_a: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST)
        last_sample_s |=> strobe_out_s)
        else $error("block strobe missing after last sample");
    block_restart_a: assert property ( // [R10]
        @(posedge REF_CLK) disable iff (RST)
        det_en_r && blk_vld_r |-> acc_r == '0 && cnt_r == '0)
        else $error("block did not restart");
    length_join_a: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RST)
        wr_take && idx_ok && idx == IDX_LEN_TOP |=>
        block_length[LEN_W-1] == $past(PWDATA[0]))
        else $error("top length bit not stored");
    status_sticky_a: assert property (@(posedge REF_CLK) disable iff (RST)
        status_r[ST_BLOCK] && !(wr_take && idx == IDX_STATUS) |=>
        status_r[ST_BLOCK])
        else $error("status bit lost");
    irq_level_a: assert property (@(posedge REF_CLK) disable iff (RST)
        |(status_r & mask_r) |=> IRQ)
        else $error("interrupt not raised");

    // Lane magnitudes rebuilt apart, so a broken shared loop shows up
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [SAMP_W-1:0] raw;
        logic [MAG_W-1:0] lane_mag;
        assign raw = SAMPLE_DATA[g*SAMP_W +: SAMP_W];
        assign lane_mag = raw[SAMP_W-1] ? ~raw + 1'b1 : raw;
        lane_bound_a: assert property ( // [R3]
            @(posedge REF_CLK) disable iff (RST)
            SAMPLE_VALID |=> red_r >= $past(lane_mag))
            else $error("reduced sample below a lane magnitude");
    end
endmodule : peak_detector

// >>> bench/tb_block_peak_power_detector.sv
// Self-checking bench for the block peak power detector
`timescale 1ns/100ps
module tb_block_peak_power_detector;
    import peak_det_pkg::*;
    // ************************************************
    // Signals
    // ************************************************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic s_valid = 1'b0;
    logic [LANES*SAMP_W-1:0] s_data = '0;
    logic blk_strobe;
    logic [MAG_W-1:0] blk_peak;
    logic flag_a;
    logic flag_b;
    logic irq;
    int bad_count = 0;
    int checked = 0;
    logic [MAG_W-1:0] peaks[$];
    logic [31:0] rd;
    logic err;
    logic [7:0] all_idx[13] = '{IDX_ENABLE, IDX_LEN_LOW, IDX_LEN_MID,
        IDX_LEN_TOP, IDX_UPPER_A, IDX_LOWER_A, IDX_UPPER_B, IDX_LOWER_B,
        IDX_HOLD_LOW, IDX_HOLD_HIGH, IDX_STATUS, IDX_MASK, IDX_LIVE};
    logic [7:0] rw_idx[8] = '{IDX_LEN_LOW, IDX_LEN_MID, IDX_UPPER_A,
        IDX_LOWER_A, IDX_UPPER_B, IDX_LOWER_B, IDX_HOLD_LOW, IDX_HOLD_HIGH};

    always #25 ref_clk = ~ref_clk;

    peak_detector dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SAMPLE_VALID(s_valid), .SAMPLE_DATA(s_data),
        .BLOCK_STROBE(blk_strobe), .BLOCK_PEAK(blk_peak), .FLAG_A(flag_a),
        .FLAG_B(flag_b), .IRQ(irq));

    // Collect every finished block peak in order
    always @(posedge ref_clk) begin
        if (blk_strobe === 1'b1) begin
            peaks.push_back(blk_peak);
        end
    end

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [MAG_W-1:0] mag(input logic [SAMP_W-1:0] s);
        return s[SAMP_W-1] ? -s : s;
    endfunction : mag

    function automatic logic [LANES*SAMP_W-1:0] one(input int v);
        return {{((LANES-1)*SAMP_W){1'b0}}, SAMP_W'(v)};
    endfunction : one

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // Request held until pready is seen high; no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        if (n >= 40) chk("apb answer", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] idx,
                          input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(name, exp, rd);
        chk("slave error", 0, err);
    endtask : rd_chk

    task automatic send(input logic [LANES*SAMP_W-1:0] d);
        @(posedge ref_clk);
        s_valid <= 1'b1;
        s_data <= d;
    endtask : send

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            s_valid <= 1'b0;
        end
    endtask : idle

    // One-sample block, then time for the flag to reach the port
    task automatic pulse(input int v);
        send(one(v));
        idle(6);
    endtask : pulse

    // Back-to-back random blocks; full negative scale as a corner
    task automatic blocks(input int len, input int nblk);
        logic [LANES*SAMP_W-1:0] d;
        logic [SAMP_W-1:0] s;
        logic [MAG_W-1:0] pk;
        logic [MAG_W-1:0] exp_q[$];
        peaks.delete();
        apb(1'b1, IDX_LEN_LOW, len[7:0]);
        apb(1'b1, IDX_LEN_MID, len[15:8]);
        for (int b = 0; b < nblk; b++) begin
            pk = '0;
            for (int i = 0; i < len; i++) begin
                for (int l = 0; l < LANES; l++) begin
                    s = SAMP_W'($urandom);
                    if (b == 0 && i == 0 && l == 3) s = 14'h2000;
                    d[l*SAMP_W+:SAMP_W] = s;
                    if (mag(s) > pk) pk = mag(s);
                end
                send(d);
            end
            exp_q.push_back(pk);
        end
        idle(8);
        chk("block count", exp_q.size(), peaks.size());
        foreach (exp_q[i]) begin
            if (i < peaks.size()) chk("block peak", exp_q[i], peaks[i]);
        end
    endtask : blocks

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        void'($urandom(4856));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (all_idx[i]) rd_chk("reset value", all_idx[i], 0);
        apb(1'b0, 8'h05, 8'h00);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        foreach (rw_idx[i]) begin
            logic [7:0] v;
            v = 8'($urandom);
            apb(1'b1, rw_idx[i], v);
            rd_chk("readback", rw_idx[i], {24'h000000, v});
        end
        apb(1'b1, IDX_LEN_TOP, 8'h01);
        rd_chk("length top", IDX_LEN_TOP, 1);
        apb(1'b1, IDX_LEN_TOP, 8'h00);
        // Detector still off: samples must be ignored
        apb(1'b1, IDX_LEN_LOW, 8'h01);
        apb(1'b1, IDX_LEN_MID, 8'h00);
        peaks.delete();
        repeat (4) send(one($urandom_range(0, 8191)));
        idle(8);
        chk("strobes while off", 0, peaks.size());
        apb(1'b1, IDX_ENABLE, 8'h01);
        blocks($urandom_range(1, 6), 3);
        blocks(258, 2);
        blocks(80, 2);
        blocks(1, 4);
        // Flags: pair A 128/64, pair B 192/32, hold-off 20 cycles
        apb(1'b1, IDX_UPPER_A, 8'h80);
        apb(1'b1, IDX_LOWER_A, 8'h40);
        apb(1'b1, IDX_UPPER_B, 8'hC0);
        apb(1'b1, IDX_LOWER_B, 8'h20);
        apb(1'b1, IDX_HOLD_LOW, 8'h14);
        apb(1'b1, IDX_HOLD_HIGH, 8'h00);
        apb(1'b1, IDX_ENABLE, 8'h00);
        apb(1'b1, IDX_ENABLE, 8'h01);
        apb(1'b1, IDX_STATUS, 8'h07);
        pulse(4096);
        chk("flag a at level 128", 0, flag_a);
        pulse(4128);
        chk("flag a set", 1, flag_a);
        chk("flag b clear", 0, flag_b);
        pulse(7000);
        chk("flag b set", 1, flag_b);
        rd_chk("live flags", IDX_LIVE, 32'h00000003);
        pulse(3000);
        idle(40);
        chk("flag a in band", 1, flag_a);
        chk("flag b in band", 1, flag_b);
        pulse(1000);
        chk("flag a hold", 1, flag_a);
        chk("flag b hold", 1, flag_b);
        // Hold-off 20: the port stays high up to 25 edges after the send
        idle(19);
        chk("flag a hold end", 1, flag_a);
        chk("flag b hold end", 1, flag_b);
        idle(1);
        chk("flag a release", 0, flag_a);
        chk("flag b release", 0, flag_b);
        // Interrupt: sticky status, mask, write one to clear
        rd_chk("status", IDX_STATUS, 32'h00000007);
        chk("irq masked", 0, irq);
        apb(1'b1, IDX_MASK, 8'h01);
        idle(2);
        chk("irq on", 1, irq);
        apb(1'b1, IDX_STATUS, 8'h01);
        idle(2);
        chk("irq cleared", 0, irq);
        rd_chk("status left", IDX_STATUS, 32'h00000006);
        // Disabling drops a standing flag at once
        pulse(5000);
        chk("flag a again", 1, flag_a);
        apb(1'b1, IDX_ENABLE, 8'h00);
        idle(3);
        chk("flag a off", 0, flag_a);
        print_verdict();
    end

    // Run needs about a thousand cycles; a hang ends well past that
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end
endmodule : tb_block_peak_power_detector
